// [dv/hfs_monitor.sv]
// Purpose: port checker for the vent/cool fault supervisor
// Assumes: contacts settle within a few cycles of a change
// Notes: bound into every hfs_supervisor instance
`timescale 1ns/1ps
`default_nettype none
module hfs_monitor
  import hfs_pkg::*;
#(
  parameter int TICK_LEN = 20,
  parameter int DEBOUNCE_LEN = 4
) (
  input wire logic clk_sys_in,
  input wire logic reset_n_in,
  input wire logic [1:0] mode_sel_in,
  input wire logic lockout_trip_input,
  input wire logic fan_run_out,
  input wire logic compressor_run_out,
  input wire logic lockout_out,
  input wire logic retry_fault_a_indicator,
  input wire logic retry_fault_b_indicator,
  input wire logic retry_fault_c_indicator,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic [31:0] wb_dat_out,
  input wire logic wb_ack_out
);
  // ------
  // saturating cycle counters
  // ------
  typedef struct packed {
    logic [31:0] quiet;
    logic [31:0] run;
    logic [31:0] trip;
  } hfs_mon_t;
  hfs_mon_t mon_q;
  hfs_mon_t mon_d;
  logic runs;
  logic [2:0] inds;
  assign runs = fan_run_out | compressor_run_out;
  assign inds = {retry_fault_c_indicator, retry_fault_b_indicator, retry_fault_a_indicator};
  always_comb begin
    mon_d = mon_q;
    mon_d.quiet = runs ? 32'h0 : mon_q.quiet + 32'(mon_q.quiet != 32'hffff_ffff);
    mon_d.run = (mode_sel_in == MODE_OFF) ? 32'h0 : mon_q.run + 32'(mon_q.run != 32'hffff_ffff);
    mon_d.trip = !lockout_trip_input ? 32'h0 : mon_q.trip + 32'(mon_q.trip != 32'hffff_ffff);
  end
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      mon_q <= '0;
    end else begin
      mon_q <= mon_d;
    end
  end
  // ------
  // properties
  // ------
  default clocking mon_cb @(posedge clk_sys_in); endclocking
  default disable iff (!reset_n_in);
  sequence wb_req;
    wb_cyc_in && wb_stb_in && !wb_ack_out;
  endsequence
  sequence trip_held;
    mon_q.trip > DEBOUNCE_LEN + 8;
  endsequence
  a_ack_answer: assert property (wb_req |=> wb_ack_out) else $error("ack missing");
  a_ack_single: assert property (wb_ack_out |=> !wb_ack_out) else $error("ack too long");
  a_dat_idle: assert property (!wb_ack_out |-> wb_dat_out == 32'h0) else $error("stray data");
  a_trip_runs_off: assert property (trip_held |-> !runs)
    else $error("run during trip");
  a_trip_no_ind: assert property (trip_held |-> inds == 3'h0)
    else $error("indicator during trip");
  a_lock_holds: assert property (lockout_out && mode_sel_in != MODE_OFF |=> lockout_out)
    else $error("lockout dropped");
  a_lock_quiet: assert property (lockout_out |-> !runs)
    else $error("run in lockout");
  a_lock_delay: assert property ($rose(lockout_out) |-> mon_q.quiet >= 9 * TICK_LEN)
    else $error("lockout too early");
  a_start_delay: assert property ($rose(fan_run_out) |-> mon_q.run >= 2 * TICK_LEN)
    else $error("fan too early");
  a_comp_with_fan: assert property (compressor_run_out |-> fan_run_out)
    else $error("compressor without fan");
endmodule : hfs_monitor
bind hfs_supervisor hfs_monitor #(.TICK_LEN(TICK_LEN), .DEBOUNCE_LEN(DEBOUNCE_LEN))
  hfs_monitor_inst (.clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in),
  .mode_sel_in(mode_sel_in), .lockout_trip_input(lockout_trip_input),
  .fan_run_out(fan_run_out), .compressor_run_out(compressor_run_out),
  .lockout_out(lockout_out), .retry_fault_a_indicator(retry_fault_a_indicator),
  .retry_fault_b_indicator(retry_fault_b_indicator),
  .retry_fault_c_indicator(retry_fault_c_indicator), .wb_cyc_in(wb_cyc_in),
  .wb_stb_in(wb_stb_in), .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out));
`default_nettype wire

// [dv/hfs_panel_model.sv]
// Purpose: selector, comparators and fault contacts in front of the block
// Assumes: want_in follows the pin layout of the package
// Notes: every change chatters four cycles before it settles
`timescale 1ns/1ps
`default_nettype none
module hfs_panel_model
  import hfs_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic reset_n_in,
  input wire logic [IN_W-1:0] want_in,
  output logic [IN_W-1:0] pins_out
);
  typedef struct packed {
    logic [IN_W-1:0] pins;
    logic [IN_W-1:0] chg;
    logic [2:0] bounce;
  } hfs_pnl_t;
  hfs_pnl_t pnl_q;
  hfs_pnl_t pnl_d;
  always_comb begin
    pnl_d = pnl_q;
    if (pnl_q.bounce != 3'h0) begin
      pnl_d.pins = pnl_q.pins ^ pnl_q.chg;
      pnl_d.bounce = pnl_q.bounce - 3'h1;
    end else if (want_in != pnl_q.pins) begin
      pnl_d.chg = want_in ^ pnl_q.pins;
      pnl_d.pins = want_in; // high is contacts open, fault active
      pnl_d.bounce = 3'h4;
    end
  end
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pnl_q <= '0;
    end else begin
      pnl_q <= pnl_d;
    end
  end
  assign pins_out = pnl_q.pins;
endmodule : hfs_panel_model
`default_nettype wire

// [dv/tb_top.sv]
// Purpose: self-checking bench for the vent/cool fault supervisor
// Assumes: one second is TL cycles
// Notes: phase checks sit mid-phase to absorb tick alignment
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import hfs_pkg::*;
  localparam int TL = 20;
  logic clk_sys_in;
  logic reset_n_in = 1'b0;
  logic [IN_W-1:0] panel_q = 9'h100;
  logic [IN_W-1:0] pins;
  logic wb_cyc = 1'b0;
  logic wb_stb = 1'b0;
  logic wb_we = 1'b0;
  logic [ADR_W-1:0] wb_adr = 4'h0;
  logic [3:0] wb_sel = 4'h0;
  logic [31:0] wb_dat = 32'h0;
  logic [31:0] wb_rdat;
  logic [31:0] rd;
  logic wb_ack, fan, comp, lock;
  logic [2:0] ind;
  logic [5:0] outs;
  int num_errors = 0;
  int comparisons = 0;
  assign outs = {ind, lock, comp, fan};
  hfs_panel_model hfs_panel_model_inst (.clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in),
    .want_in(panel_q), .pins_out(pins));
  hfs_supervisor #(.TICK_LEN(TL), .DEBOUNCE_LEN(4)) hfs_supervisor_inst (
    .clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in), .mode_sel_in(pins[1:0]),
    .cool_demand_in(pins[IN_DEMAND]), .ambient_warm_in(pins[IN_AMB]),
    .lockout_trip_input(pins[IN_TRIP]), .retry_fault_a_input(pins[5]),
    .retry_fault_b_input(pins[6]), .retry_fault_c_input(pins[7]),
    .fault_gating_input(pins[IN_GATE]), .fan_run_out(fan), .compressor_run_out(comp),
    .lockout_out(lock), .retry_fault_a_indicator(ind[0]), .retry_fault_b_indicator(ind[1]),
    .retry_fault_c_indicator(ind[2]), .wb_cyc_in(wb_cyc), .wb_stb_in(wb_stb),
    .wb_we_in(wb_we), .wb_adr_in(wb_adr), .wb_sel_in(wb_sel), .wb_dat_in(wb_dat),
    .wb_dat_out(wb_rdat), .wb_ack_out(wb_ack));
  initial begin
    clk_sys_in = 1'b0;
    forever #5 clk_sys_in = ~clk_sys_in;
  end
  // ------
  // tasks
  // ------
  task finish_test();
    $display("comparisons %0d num_errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : finish_test
  task bad(string what, logic [31:0] exp, logic [31:0] got);
    num_errors++;
    $display("BAD %s expected %h seen %h", what, exp, got);
  endtask : bad
  task chk_reg(string what, logic [31:0] exp, logic [31:0] got);
    comparisons++;
    if (got !== exp) bad(what, exp, got);
  endtask : chk_reg
  task chk_out(string what, logic [5:0] exp);
    comparisons++;
    if (outs !== exp) bad(what, 32'(exp), 32'(outs));
  endtask : chk_out
  task wb_io(logic we, logic [ADR_W-1:0] adr, logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clk_sys_in);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= adr;
    wb_sel <= 4'hf;
    wb_dat <= wd;
    do begin
      @(posedge clk_sys_in);
      n++;
    end while (wb_ack !== 1'b1 && n < 50);
    if (n >= 50) bad("ack", 32'h1, 32'h0);
    rd = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask : wb_io
  task secs(int hs);
    repeat (hs * TL / 2) @(posedge clk_sys_in);
  endtask : secs
  task set_pin(int idx, logic v);
    @(posedge clk_sys_in);
    panel_q[idx] <= v;
  endtask : set_pin
  task pwr_cycle();
    @(posedge clk_sys_in);
    reset_n_in <= 1'b0;
    repeat (3) @(posedge clk_sys_in);
    reset_n_in <= 1'b1;
  endtask : pwr_cycle
  task reselect(logic [1:0] m, logic [5:0] normal);
    @(posedge clk_sys_in);
    panel_q[1:0] <= MODE_OFF;
    secs(2);
    @(posedge clk_sys_in);
    panel_q[1:0] <= m;
    secs(4);
    chk_out("start hold", 6'h00);
    secs(2);
    chk_out("started", normal);
  endtask : reselect
  task wait_hi(int b);
    int n;
    n = 0;
    while (outs[b] !== 1'b1 && n < 4 * TL) begin
      @(posedge clk_sys_in);
      n++;
    end
    if (n >= 4 * TL) bad("indicator rise", 32'h1, 32'h0);
  endtask : wait_hi
  task momentary(int i, logic [5:0] normal);
    set_pin(IN_RETRY_LO + i, 1'b1);
    wait_hi(3 + i);
    secs(2);
    set_pin(IN_RETRY_LO + i, 1'b0);
    secs(6);
    chk_out("blip lit", (6'h08 << i) | 6'h01);
    secs(10);
    chk_out("blip pause", 6'h00);
    secs(4);
    chk_out("blip run", 6'h01);
    secs(4);
    chk_out("blip fan off", 6'h00);
    secs(6);
    chk_out("blip done", normal);
  endtask : momentary
  task trip_pulse(logic [5:0] normal);
    set_pin(IN_TRIP, 1'b1);
    secs(4);
    chk_out("trip pulse", 6'h00);
    set_pin(IN_TRIP, 1'b0);
    secs(12);
    chk_out("trip hold", 6'h00);
    secs(10);
    chk_out("trip over", normal);
  endtask : trip_pulse
  // ------
  // tests
  // ------
  initial begin
    repeat (30000) @(posedge clk_sys_in);
    num_errors++;
    finish_test();
  end
  initial begin
    pwr_cycle();
    wb_io(1'b0, REG_CTRL, 32'h0);
    chk_reg("ctrl reset", 32'(CTRL_EN_RST), rd);
    wb_io(1'b0, REG_STATUS, 32'h0);
    chk_reg("status reset", 32'h0, rd);
    wb_io(1'b1, REG_CTRL, 32'h0);
    wb_io(1'b0, REG_CTRL, 32'h0);
    chk_reg("ctrl off", 32'h0, rd);
    wb_io(1'b1, REG_CTRL, 32'h1);
    wb_io(1'b1, 4'hc, 32'hffff_ffff);
    wb_io(1'b0, 4'hc, 32'h0);
    chk_reg("unmapped", 32'h0, rd);
    wb_io(1'b0, REG_INPUTS, 32'h0);
    chk_reg("inputs", 32'h1 << IN_GATE, rd);
    $display("test registers done");
    reselect(MODE_VENT, 6'h01);
    set_pin(IN_DEMAND, 1'b1);
    secs(4);
    chk_out("vent demand", 6'h01);
    set_pin(IN_DEMAND, 1'b0);
    pwr_cycle();
    secs(4);
    chk_out("restore hold", 6'h00);
    secs(2);
    chk_out("restored", 6'h01);
    secs(14);
    $display("test vent start done");
    for (int i = 0; i < 3; i++) begin
      set_pin(IN_RETRY_LO + i, 1'b1);
      for (int j = 0; j < 3; j++) begin
        wait_hi(3 + i);
        secs(8);
        chk_out("retry lit", (6'h08 << i) | 6'h01);
        secs(10);
        chk_out("retry pause", 6'h00);
        secs(4);
        chk_out("retry run", 6'h01);
      end
      secs(20);
      chk_out("retry latched", (6'h08 << i) | 6'h01);
      set_pin(IN_RETRY_LO + i, 1'b0);
      secs(4);
      chk_out("latch held", (6'h08 << i) | 6'h01);
      reselect(MODE_VENT, 6'h01);
      secs(14);
    end
    momentary(1, 6'h01);
    trip_pulse(6'h01);
    set_pin(IN_TRIP, 1'b1);
    secs(16);
    chk_out("trip waiting", 6'h00);
    secs(8);
    chk_out("lockout", 6'h04);
    set_pin(IN_TRIP, 1'b0);
    secs(4);
    chk_out("lockout kept", 6'h04);
    wb_io(1'b0, REG_STATUS, 32'h0);
    chk_reg("status lock", 32'(ST_LOCKOUT) << ST_STATE_LO | 32'h1 << ST_LOCK_BIT, rd);
    set_pin(IN_TRIP, 1'b1);
    reselect(MODE_VENT, 6'h00);
    secs(18);
    chk_out("lockout again", 6'h04);
    $display("test vent faults done");
    set_pin(IN_TRIP, 1'b0);
    set_pin(IN_GATE, 1'b0);
    reselect(MODE_VENT, 6'h01);
    for (int i = 0; i < 3; i++) set_pin(IN_RETRY_LO + i, 1'b1);
    secs(6);
    chk_out("gate low", 6'h01);
    set_pin(IN_GATE, 1'b1);
    wait_hi(3);
    secs(2);
    chk_out("all lit", 6'h39);
    set_pin(IN_TRIP, 1'b1);
    secs(2);
    chk_out("trip masks", 6'h00);
    secs(22);
    chk_out("masked lockout", 6'h04);
    for (int i = 0; i < 3; i++) set_pin(IN_RETRY_LO + i, 1'b0);
    set_pin(IN_TRIP, 1'b0);
    set_pin(IN_DEMAND, 1'b1);
    $display("test trip mask done");
    reselect(MODE_COOL, 6'h03);
    set_pin(IN_DEMAND, 1'b0);
    secs(2);
    chk_out("no demand", 6'h01);
    set_pin(IN_AMB, 1'b1);
    secs(2);
    chk_out("ambient rest", 6'h00);
    secs(5);
    chk_out("ambient run", 6'h03);
    set_pin(IN_AMB, 1'b0);
    set_pin(IN_DEMAND, 1'b1);
    momentary(2, 6'h03);
    trip_pulse(6'h03);
    set_pin(IN_TRIP, 1'b1);
    secs(24);
    chk_out("cool lockout", 6'h04);
    reselect(MODE_COOL, 6'h00);
    set_pin(IN_TRIP, 1'b0);
    secs(20);
    chk_out("cool resumed", 6'h03);
    set_pin(IN_MODE_LO, 1'b1);
    secs(4);
    chk_out("heat idle", 6'h00);
    $display("test cool done");
    finish_test();
  end
endmodule : tb_top
`default_nettype wire

// [logic/hfs_input_filter.sv]
// Purpose: synchronise and debounce the selector and contact inputs
// Assumes: inputs are slow mechanical or comparator levels
// Notes: output changes only after a level is stable for the full window
`timescale 1ns/1ps
`default_nettype none
module hfs_input_filter
  import hfs_pkg::*;
#(
  parameter int DEBOUNCE_LEN = DEBOUNCE_CYCLES
) (
  input wire logic clk_sys_in,
  input wire logic reset_n_in,
  input wire logic [IN_W-1:0] raw_in,
  output logic [IN_W-1:0] clean_out
);
  typedef struct packed {
    logic [IN_W-1:0] sync1;
    logic [IN_W-1:0] sync2;
    logic [IN_W-1:0] clean;
    logic [IN_W-1:0][DB_CNT_W-1:0] cnt;
  } hfs_filt_t;

  localparam logic [DB_CNT_W-1:0] DB_LAST = DB_CNT_W'(DEBOUNCE_LEN - 1);

  hfs_filt_t q, d;

  // ---------------------------------------------------------------
  // per-input stability counters
  // ---------------------------------------------------------------
  always_comb begin
    d = q;
    d.sync1 = raw_in;
    d.sync2 = q.sync1;
    for (int i = 0; i < IN_W; i++) begin
      if (q.sync2[i] == q.clean[i]) begin
        d.cnt[i] = '0;
      end else if (q.cnt[i] == DB_LAST) begin
        d.clean[i] = q.sync2[i];
        d.cnt[i] = '0;
      end else begin
        d.cnt[i] = q.cnt[i] + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign clean_out = q.clean;
endmodule : hfs_input_filter
`default_nettype wire

// [logic/hfs_pkg.sv]
// Purpose: constants and types for the vent/cool fault supervisor
// Assumes: 100 MHz system clock, one-second time base
// Notes: fault contacts are active high (contacts open)
package hfs_pkg;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_PERIOD_NS = 1_000_000_000;
  localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int TICK_W = 27;
  localparam int DEBOUNCE_NS = 20_000_000;
  localparam int DEBOUNCE_CYCLES = DEBOUNCE_NS / CLK_PERIOD_NS;
  localparam int DB_CNT_W = 22;
  localparam int SECS_W = 4;
  localparam logic [SECS_W-1:0] START_S = 4'h2;
  localparam logic [SECS_W-1:0] RETRY_IND_S = 4'h8;
  localparam logic [SECS_W-1:0] RETRY_PAUSE_S = 4'h2;
  localparam logic [SECS_W-1:0] RETRY_RUN_S = 4'h2;
  localparam logic [SECS_W-1:0] RETRY_FANOFF_S = 4'h2;
  localparam logic [SECS_W-1:0] AMB_REST_S = 4'h2;
  localparam logic [SECS_W-1:0] TRIP_HOLD_S = 4'ha;
  localparam logic [1:0] RETRY_CYCLES = 2'h3;
  // ---------------------------------------------------------------
  // selector and input vector layout
  // ---------------------------------------------------------------
  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_VENT = 2'h1;
  localparam logic [1:0] MODE_COOL = 2'h2;
  localparam logic [1:0] MODE_HEAT = 2'h3;
  localparam int IN_W = 9;
  localparam int IN_MODE_LO = 0;
  localparam int IN_DEMAND = 2;
  localparam int IN_AMB = 3;
  localparam int IN_TRIP = 4;
  localparam int IN_RETRY_LO = 5;
  localparam int IN_GATE = 8;
  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam int ADR_W = 4;
  localparam logic [ADR_W-1:0] REG_CTRL = 4'h0;
  localparam logic [ADR_W-1:0] REG_STATUS = 4'h4;
  localparam logic [ADR_W-1:0] REG_INPUTS = 4'h8;
  localparam int CTRL_EN_BIT = 0;
  localparam logic CTRL_EN_RST = 1'b1;
  localparam int ST_FAN_BIT = 0;
  localparam int ST_COMP_BIT = 1;
  localparam int ST_LOCK_BIT = 2;
  localparam int ST_IND_LO = 4;
  localparam int ST_LATCH_LO = 8;
  localparam int ST_STATE_LO = 12;
  // ---------------------------------------------------------------
  // supervisor states
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_OFF,
    ST_START,
    ST_RUN,
    ST_AMB_REST,
    ST_RETRY_IND,
    ST_RETRY_PAUSE,
    ST_RETRY_RUN,
    ST_RETRY_FANOFF,
    ST_RETRY_LATCH,
    ST_TRIP,
    ST_LOCKOUT
  } hfs_state_t;
endpackage : hfs_pkg

// [logic/hfs_supervisor.sv]
// Purpose: vent/cool supervisory logic with retry and lockout handling
// Assumes: inputs from selector, comparators and fault contacts; classic
//   wishbone register access
// Notes: heat position and off both hold the block idle
`timescale 1ns/1ps
`default_nettype none
module hfs_supervisor
  import hfs_pkg::*;
#(
  parameter int TICK_LEN = TICK_CYCLES,
  parameter int DEBOUNCE_LEN = DEBOUNCE_CYCLES
) (
  input wire logic clk_sys_in,
  input wire logic reset_n_in,
  input wire logic [1:0] mode_sel_in,
  input wire logic cool_demand_in,
  input wire logic ambient_warm_in,
  input wire logic lockout_trip_input,
  input wire logic retry_fault_a_input,
  input wire logic retry_fault_b_input,
  input wire logic retry_fault_c_input,
  input wire logic fault_gating_input,
  output logic fan_run_out,
  output logic compressor_run_out,
  output logic lockout_out,
  output logic retry_fault_a_indicator,
  output logic retry_fault_b_indicator,
  output logic retry_fault_c_indicator,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [ADR_W-1:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out
);
  // ---------------------------------------------------------------
  // state record
  // ---------------------------------------------------------------
  typedef struct packed {
    hfs_state_t state;
    logic [TICK_W-1:0] pre;
    logic [SECS_W-1:0] secs;
    logic [1:0] retry_cnt;
    logic [2:0] ind_mask;
    logic [2:0] latch_mask;
    logic prev_amb;
    logic fan;
    logic comp;
    logic lock;
    logic [2:0] ind;
    logic ctrl_en;
    logic ack;
    logic [31:0] rdat;
  } hfs_sup_t;

  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_LEN - 1);

  hfs_sup_t q, d;
  logic [IN_W-1:0] raw;
  logic [IN_W-1:0] clean;

  // ---------------------------------------------------------------
  // input conditioning
  // ---------------------------------------------------------------
  assign raw = {fault_gating_input, retry_fault_c_input, retry_fault_b_input,
                retry_fault_a_input, lockout_trip_input, ambient_warm_in,
                cool_demand_in, mode_sel_in};

  // the state machine sees only debounced levels, never a raw pin
  hfs_input_filter #(
    .DEBOUNCE_LEN(DEBOUNCE_LEN)
  ) u_filter (
    .clk_sys_in(clk_sys_in),
    .reset_n_in(reset_n_in),
    .raw_in(raw),
    .clean_out(clean)
  );

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // true on the tick that closes the last second of a phase
  function automatic logic phase_done(input logic tick, input logic [SECS_W-1:0] secs,
                                      input logic [SECS_W-1:0] len);
    phase_done = tick && (secs == len - 1'b1);
  endfunction : phase_done

  // ---------------------------------------------------------------
  // next-state logic
  // ---------------------------------------------------------------
  always_comb begin
    logic [1:0] mode;
    logic demand;
    logic amb;
    logic trip;
    logic [2:0] gated;
    logic operating;
    logic cool;
    logic tick;
    logic [1:0] cnt_next;
    logic access;
    hfs_state_t nxt;
    // ---------------------------------------------------------------
    // input decode
    // ---------------------------------------------------------------
    mode = clean[IN_MODE_LO +: 2];
    demand = clean[IN_DEMAND];
    amb = clean[IN_AMB];
    trip = clean[IN_TRIP];
    // retry contacts act only while the gating contact is active
    gated = clean[IN_RETRY_LO +: 3] & {3{clean[IN_GATE]}};
    operating = q.ctrl_en && (mode == MODE_VENT || mode == MODE_COOL);
    cool = (mode == MODE_COOL);
    cnt_next = q.retry_cnt + 2'h1;
    access = wb_cyc_in && wb_stb_in && !q.ack;
    d = q;
    nxt = q.state;

    // ---------------------------------------------------------------
    // time base
    // ---------------------------------------------------------------
    // one-second time base, restarted at every state change
    tick = (q.pre == TICK_LAST);
    d.pre = tick ? '0 : q.pre + 1'b1;
    if (tick) begin
      d.secs = q.secs + 1'b1;
    end
    // tracked in every state, so entering cool while warm shows no edge
    d.prev_amb = amb;

    // ---------------------------------------------------------------
    // state transitions
    // ---------------------------------------------------------------
    // off, heat or a cleared enable all act as the off/reset position
    if (!operating) begin
      nxt = ST_OFF;
    end else begin
      unique case (q.state)
        ST_OFF: begin
          // trip present on leaving off/reset goes straight to the hold
          nxt = trip ? ST_TRIP : ST_START;
        end
        ST_START: begin
          if (trip) begin
            nxt = ST_TRIP;
          end else if (phase_done(tick, q.secs, START_S)) begin
            nxt = ST_RUN;
          end
        end
        ST_RUN: begin
          // trip outranks retry faults, which outrank an ambient rest
          if (trip) begin
            nxt = ST_TRIP;
          end else if (|gated) begin
            nxt = ST_RETRY_IND;
            d.ind_mask = gated;
            d.retry_cnt = '0;
          end else if (cool && amb && !q.prev_amb) begin
            nxt = ST_AMB_REST;
          end
        end
        ST_AMB_REST: begin
          if (trip) begin
            nxt = ST_TRIP;
          end else if (phase_done(tick, q.secs, AMB_REST_S)) begin
            nxt = ST_RUN;
          end
        end
        ST_RETRY_IND: begin
          if (trip) begin
            nxt = ST_TRIP;
          end else if (phase_done(tick, q.secs, RETRY_IND_S)) begin
            nxt = ST_RETRY_PAUSE;
          end
        end
        ST_RETRY_PAUSE: begin
          if (trip) begin
            nxt = ST_TRIP;
          end else if (phase_done(tick, q.secs, RETRY_PAUSE_S)) begin
            nxt = ST_RETRY_RUN;
          end
        end
        ST_RETRY_RUN: begin
          if (trip) begin
            nxt = ST_TRIP;
          end else if (phase_done(tick, q.secs, RETRY_RUN_S)) begin
            // mask was taken at cycle start; a new contact cannot join it
            if (|(gated & q.ind_mask)) begin
              if (cnt_next == RETRY_CYCLES) begin
                nxt = ST_RETRY_LATCH;
                d.latch_mask = q.ind_mask;
              end else begin
                nxt = ST_RETRY_IND;
                d.retry_cnt = cnt_next;
              end
            end else begin
              nxt = ST_RETRY_FANOFF;
            end
          end
        end
        ST_RETRY_FANOFF: begin
          if (trip) begin
            nxt = ST_TRIP;
          end else if (phase_done(tick, q.secs, RETRY_FANOFF_S)) begin
            nxt = ST_RUN;
          end
        end
        ST_RETRY_LATCH: begin
          if (trip) begin
            nxt = ST_TRIP;
          end
        end
        ST_TRIP: begin
          // a trip gone before the hold ends returns to any latched retry
          if (phase_done(tick, q.secs, TRIP_HOLD_S)) begin
            if (trip) begin
              nxt = ST_LOCKOUT;
            end else if (|q.latch_mask) begin
              nxt = ST_RETRY_LATCH;
            end else begin
              nxt = ST_RUN;
            end
          end
        end
        ST_LOCKOUT: begin
          // only leaving the operating modes clears a lockout
          nxt = ST_LOCKOUT;
        end
      endcase
    end

    // ---------------------------------------------------------------
    // phase timer and latch clear
    // ---------------------------------------------------------------
    // every phase is timed from its own entry edge
    if (nxt != q.state) begin
      d.pre = '0;
      d.secs = '0;
    end
    d.state = nxt;

    if (nxt == ST_OFF) begin
      d.latch_mask = '0;
      d.ind_mask = '0;
      d.retry_cnt = '0;
    end

    // ---------------------------------------------------------------
    // outputs follow the next state so they change with it
    // ---------------------------------------------------------------
    d.fan = 1'b0;
    d.comp = 1'b0;
    d.ind = '0;
    d.lock = 1'b0;
    unique case (nxt)
      ST_RUN: begin
        d.fan = 1'b1;
        d.comp = cool && (demand || amb);
      end
      ST_RETRY_IND: begin
        d.fan = 1'b1;
        d.ind = d.ind_mask;
      end
      ST_RETRY_RUN: begin
        d.fan = 1'b1;
      end
      ST_RETRY_LATCH: begin
        d.fan = 1'b1;
        d.ind = d.latch_mask;
      end
      ST_LOCKOUT: begin
        d.lock = 1'b1;
      end
      ST_OFF, ST_START, ST_AMB_REST, ST_RETRY_PAUSE, ST_RETRY_FANOFF, ST_TRIP: begin
        d.fan = 1'b0;
      end
    endcase

    // ---------------------------------------------------------------
    // register access
    // ---------------------------------------------------------------
    // ack stands one cycle; a request still held after it is taken again the next cycle
    // read data is zero outside the ack cycle
    d.ack = access;
    d.rdat = '0;
    if (access) begin
      if (wb_we_in) begin
        if (wb_adr_in == REG_CTRL && wb_sel_in[0]) begin
          // clearing the enable acts as off/reset and drops every latch
          d.ctrl_en = wb_dat_in[CTRL_EN_BIT];
        end
      end else begin
        unique case (wb_adr_in)
          REG_CTRL: begin
            d.rdat[CTRL_EN_BIT] = q.ctrl_en;
          end
          REG_STATUS: begin
            d.rdat[ST_FAN_BIT] = q.fan;
            d.rdat[ST_COMP_BIT] = q.comp;
            d.rdat[ST_LOCK_BIT] = q.lock;
            d.rdat[ST_IND_LO +: 3] = q.ind;
            d.rdat[ST_LATCH_LO +: 3] = q.latch_mask;
            d.rdat[ST_STATE_LO +: 4] = q.state;
          end
          REG_INPUTS: begin
            d.rdat[IN_W-1:0] = clean;
          end
          default: begin
            d.rdat = '0;
          end
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      q <= '0;
      q.state <= ST_OFF;
      // enabled from reset so the panel works without software
      q.ctrl_en <= CTRL_EN_RST;
    end else begin
      q <= d;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign fan_run_out = q.fan;
  assign compressor_run_out = q.comp;
  assign lockout_out = q.lock;
  assign retry_fault_a_indicator = q.ind[0];
  assign retry_fault_b_indicator = q.ind[1];
  assign retry_fault_c_indicator = q.ind[2];
  assign wb_dat_out = q.rdat;
  assign wb_ack_out = q.ack;
endmodule : hfs_supervisor
`default_nettype wire
